// ---- shared/pso_pkg.sv ----
/*
 * Shared constants and types for the pipelined sample output port: word widths,
 * output codes, reset values, pin positions in the synchroniser and cycle counts.
 * Assumes a 10 MHz system clock; every cycle count is derived from that period.
 */
package pso_pkg;

   // ==========================================================================
   // clocking
   // ==========================================================================
   localparam int unsigned CLK_PERIOD_NS = 100;

   // ==========================================================================
   // word layout and codes
   // ==========================================================================
   localparam int unsigned WORD_W     = 10;
   localparam int unsigned MV_W       = 16;
   localparam int unsigned CODE_STEPS = 1024;
   localparam logic [9:0]  CODE_ZERO  = 10'h000;
   localparam logic [9:0]  CODE_FULL  = 10'h3FF;
   localparam logic [9:0]  WORD_RST   = 10'h000;
   localparam int unsigned PIPE_DEPTH = 2;

   // ==========================================================================
   // pin positions in the synchroniser vector
   // ==========================================================================
   localparam int unsigned PIN_CONV_CLK = 0;
   localparam int unsigned PIN_STANDBY  = 1;
   localparam int unsigned PIN_OE_N     = 2;
   localparam int unsigned PIN_LEVEL_LO = 3;
   localparam int unsigned PIN_TOP_LO   = PIN_LEVEL_LO + MV_W;
   localparam int unsigned PIN_BOT_LO   = PIN_TOP_LO + MV_W;
   localparam int unsigned PIN_COUNT    = PIN_BOT_LO + MV_W;

   // ==========================================================================
   // timing
   // ==========================================================================
   localparam int unsigned APERTURE_NS  = 4;
   localparam int unsigned OUT_DELAY_NS = 25;
   localparam int unsigned HOLD_NS      = 12;
   localparam int unsigned WAKE_NS      = 700;

   // least times round up, longest times round down, never below one cycle
   localparam int unsigned APERTURE_CYC_RAW  = (APERTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned APERTURE_CYC      = (APERTURE_CYC_RAW < 1) ? 1 : APERTURE_CYC_RAW;
   localparam int unsigned OUT_DELAY_CYC_RAW = OUT_DELAY_NS / CLK_PERIOD_NS;
   localparam int unsigned OUT_DELAY_CYC     = (OUT_DELAY_CYC_RAW < 1) ? 1 : OUT_DELAY_CYC_RAW;
   localparam int unsigned WAKE_CYC          = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  WAKE_CYC_W        = 4'(WAKE_CYC);
   localparam logic [3:0]  WAKE_CNT_RST      = 4'h0;

   // ==========================================================================
   // operating mode
   // ==========================================================================
   typedef enum {PSO_STANDBY, PSO_RUN} pso_mode_t;

endpackage

// ---- shared/pso_quant_if.sv ----
/*
 * Carrier between the port and its quantiser: the held sample and the two
 * reference sense levels go out, the output code comes back the same cycle.
 * Assumes both ends sit on the same clock; the path is purely combinational.
 */
interface pso_quant_if;
   import pso_pkg::*;
   logic [MV_W-1:0]   sample_mv;
   logic [MV_W-1:0]   top_mv;
   logic [MV_W-1:0]   bottom_mv;
   logic [WORD_W-1:0] code;

   modport port_side (output sample_mv, output top_mv, output bottom_mv, input code);
   modport quantiser (input sample_mv, input top_mv, input bottom_mv, output code);
endinterface

// ---- rtl/pso_quantiser.sv ----
/*
 * Quantiser: maps a held sample, in millivolts, onto a ten bit straight binary
 * code across the window set by the two reference sense levels.
 * Assumes settled inputs; the result is combinational and read by the caller.
 */
module pso_quantiser
   import pso_pkg::*;
(
   pso_quant_if.quantiser q
);

   logic [MV_W-1:0]      span;
   logic [MV_W-1:0]      offset;
   logic [MV_W+9:0]      scaled;
   logic [MV_W+9:0]      ratio;

   // ==========================================================================
   // straight binary conversion with clamping at both ends
   // ==========================================================================
   always_comb begin
      span   = q.top_mv - q.bottom_mv;
      offset = q.sample_mv - q.bottom_mv;
      scaled = {offset, 10'h000};
      ratio  = (span == {MV_W{1'b0}}) ? {(MV_W+10){1'b0}} : scaled / {10'h000, span};
      if (q.sample_mv < q.bottom_mv) begin
         q.code = CODE_ZERO;
      end else if (q.sample_mv > q.top_mv || q.top_mv <= q.bottom_mv) begin
         q.code = CODE_FULL;
      end else if (ratio >= (MV_W+10)'(CODE_STEPS - 1)) begin
         q.code = CODE_FULL;
      end else begin
         q.code = ratio[WORD_W-1:0];
      end
   end

endmodule

// ---- rtl/pso_sample_port.sv ----
/*
 * Digital side of a ten bit pipelined sampling converter. The conversion clock,
 * standby request and output enable arrive as pins and are synchronised to the
 * system clock; falling edges of the conversion clock start samples, and each
 * result reaches the tristatable output word two conversion cycles later.
 * Assumes the conversion clock runs at no more than a quarter of the system
 * clock, and that the analog levels are quasi-static over a conversion cycle
 * (they are modelled as millivolt words and only pass a two flop synchroniser).
 */

// Behaviour
// - new sample on every conversion clock fall
// - result appears two cycles after its sample
// - fresh word every cycle, pipeline stays full
// - convert only with clock running, standby low
// - drive outputs while output enable low
// - standby high floats outputs unconditionally
// - input below bottom reference gives zeros
// - input above top reference gives ones
// - ten bit result, codes zero to 1023
// - output word changes after falling edge
// - previous word held briefly after fall
// - sample taken aperture delay after fall
module pso_sample_port
   import pso_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   input  wire logic              i_clk_en,
   input  wire logic              i_conv_clock,
   input  wire logic              i_standby_request,
   input  wire logic              i_output_enable_n,
   input  wire logic [MV_W-1:0]   i_analog_input,
   input  wire logic [MV_W-1:0]   i_ref_top_sense,
   input  wire logic [MV_W-1:0]   i_ref_bottom_sense,
   output logic      [WORD_W-1:0] o_data,
   output logic      [WORD_W-1:0] o_data_oe,
   output logic                   o_word_strobe,
   output logic                   o_wake_done
);

   logic [PIN_COUNT-1:0]     pin_raw;
   logic [PIN_COUNT-1:0]     pin_meta;
   logic [PIN_COUNT-1:0]     pin_sync;
   logic                     conv_clk_prev;
   logic                     conv_fall;
   logic [APERTURE_CYC-1:0]  aperture_line;
   logic [OUT_DELAY_CYC-1:0] out_delay_line;
   logic                     take_sample;
   logic                     update_out;
   logic                     standby;
   logic                     oe_n;
   pso_mode_t                mode;
   pso_mode_t                next_mode;
   logic [WORD_W-1:0]        stage_q [PIPE_DEPTH];
   logic [1:0]               fill_cnt;
   logic [3:0]               wake_cnt;
   logic                     drive;

   pso_quant_if q ();

   // ==========================================================================
   // pin synchronisers
   // ==========================================================================
   assign pin_raw = {i_ref_bottom_sense, i_ref_top_sense, i_analog_input,
                     i_output_enable_n, i_standby_request, i_conv_clock};

   // the first flop of each bit feeds only the second one
   genvar b;
   generate
      for (b = 0; b < PIN_COUNT; b++) begin : g_sync
         // standby starts asserted and output enable deasserted so nothing drives before the pins are seen
         localparam logic SYNC_RST = (b == PIN_STANDBY) || (b == PIN_OE_N);
         always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
               pin_meta[b] <= SYNC_RST;
               pin_sync[b] <= SYNC_RST;
            end else if (i_clk_en) begin
               pin_meta[b] <= pin_raw[b];
               pin_sync[b] <= pin_meta[b];
            end
         end
      end
   endgenerate

   assign standby = pin_sync[PIN_STANDBY];
   assign oe_n    = pin_sync[PIN_OE_N];

   // ==========================================================================
   // operating mode
   // ==========================================================================
   always_comb begin
      case (mode)
         PSO_STANDBY: next_mode = standby ? PSO_STANDBY : PSO_RUN;
         PSO_RUN:     next_mode = standby ? PSO_STANDBY : PSO_RUN;
         default:     next_mode = PSO_STANDBY;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         mode <= PSO_STANDBY;
      end else if (i_clk_en) begin
         mode <= next_mode;
      end
   end

   // ==========================================================================
   // conversion clock falling edge
   // ==========================================================================
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         conv_clk_prev <= 1'b0;
      end else if (i_clk_en) begin
         conv_clk_prev <= pin_sync[PIN_CONV_CLK];
      end
   end

   // a stopped conversion clock gives no edges, so conversion halts by itself
   assign conv_fall = conv_clk_prev & ~pin_sync[PIN_CONV_CLK] & (mode == PSO_RUN) & ~standby;

   // ==========================================================================
   // aperture and output delay lines
   // ==========================================================================
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         aperture_line <= '0;
      end else if (i_clk_en) begin
         // the cast keeps the low bits, so the line also works at a single cycle
         aperture_line <= APERTURE_CYC'({aperture_line, conv_fall});
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         out_delay_line <= '0;
      end else if (i_clk_en) begin
         out_delay_line <= OUT_DELAY_CYC'({out_delay_line, conv_fall});
      end
   end

   // standby drops pending work so no word moves once conversion has stopped
   assign take_sample = aperture_line[APERTURE_CYC-1] & ~standby;
   assign update_out  = out_delay_line[OUT_DELAY_CYC-1] & ~standby;

   // ==========================================================================
   // quantiser
   // ==========================================================================
   assign q.sample_mv = pin_sync[PIN_LEVEL_LO +: MV_W];
   assign q.top_mv    = pin_sync[PIN_TOP_LO +: MV_W];
   assign q.bottom_mv = pin_sync[PIN_BOT_LO +: MV_W];

   pso_quantiser u_quant (
      .q (q.quantiser)
   );

   // ==========================================================================
   // two stage result pipeline
   // ==========================================================================
   // the output stage reads stage_q[1] before a coincident sample shifts it,
   // which keeps the lag at exactly two falls while the delay lines are equal
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         stage_q[0] <= WORD_RST;
         stage_q[1] <= WORD_RST;
      end else if (i_clk_en && take_sample) begin
         stage_q[0] <= q.code;
         stage_q[1] <= stage_q[0];
      end
   end

   // old word stays on the pins until the output delay has passed
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_data <= WORD_RST;
      end else if (i_clk_en && update_out) begin
         o_data <= stage_q[PIPE_DEPTH-1];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_word_strobe <= 1'b0;
      end else if (i_clk_en) begin
         o_word_strobe <= update_out && (fill_cnt == 2'(PIPE_DEPTH));
      end
   end

   // counts samples since leaving standby so stale words are not flagged
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         fill_cnt <= 2'h0;
      end else if (i_clk_en) begin
         if (standby) begin
            fill_cnt <= 2'h0;
         end else if (take_sample && fill_cnt != 2'(PIPE_DEPTH)) begin
            fill_cnt <= fill_cnt + 2'h1;
         end
      end
   end

   // ==========================================================================
   // wake-up indication
   // ==========================================================================
   // only a hint for the capture logic; discarding results stays its duty
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         wake_cnt    <= WAKE_CNT_RST;
         o_wake_done <= 1'b0;
      end else if (i_clk_en) begin
         if (standby) begin
            wake_cnt    <= WAKE_CNT_RST;
            o_wake_done <= 1'b0;
         end else if (wake_cnt != WAKE_CYC_W) begin
            wake_cnt    <= wake_cnt + 4'h1;
            o_wake_done <= 1'b0;
         end else begin
            o_wake_done <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // output drivers
   // ==========================================================================
   assign drive = ~oe_n & ~standby;

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_data_oe <= '0;
      end else if (i_clk_en) begin
         o_data_oe <= {WORD_W{drive}};
      end
   end

endmodule

// ---- verif/pso_sample_port_properties.sv ----
/*
 * Checker for the sample output port: output drive, word update timing, strobe and wake status.
 * Assumes it is bound to the port's top module with i_clk_en held high in normal running.
 */
module pso_sample_port_properties
   import pso_pkg::*;
(
   input wire logic              i_clock,
   input wire logic              i_sys_rst,
   input wire logic              i_clk_en,
   input wire logic              i_conv_clock,
   input wire logic              i_standby_request,
   input wire logic              i_output_enable_n,
   input wire logic [MV_W-1:0]   i_analog_input,
   input wire logic [MV_W-1:0]   i_ref_top_sense,
   input wire logic [MV_W-1:0]   i_ref_bottom_sense,
   input wire logic [WORD_W-1:0] o_data,
   input wire logic [WORD_W-1:0] o_data_oe,
   input wire logic              o_word_strobe,
   input wire logic              o_wake_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] low_cnt;

   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst || !i_clk_en);

   // ==========================================================
   // helper: run of standby-low samples, saturating
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || i_standby_request) begin
         low_cnt <= 4'h0;
      end else if (i_clk_en && low_cnt != 4'hF) begin
         low_cnt <= low_cnt + 4'h1;
      end
   end

   // ==========================================================
   // properties
   sequence s_standby_held;
      i_standby_request [*4];
   endsequence
   sequence s_drive_req;
      (!i_output_enable_n && !i_standby_request) [*4];
   endsequence

   AST_OE_STANDBY: assert property (s_standby_held |-> o_data_oe == 10'h000 && !o_wake_done)
      else $error("outputs driven or wake flag set in standby");
   AST_OE_DISABLED: assert property (i_output_enable_n [*4] |-> o_data_oe == 10'h000)
      else $error("outputs driven with enable high");
   AST_OE_DRIVE: assert property (s_drive_req |-> o_data_oe == 10'h3FF)
      else $error("outputs not driven with enable low");
   AST_DATA_AFTER_FALL: assert property ($changed(o_data) |-> $past(i_conv_clock, 5)
      && !$past(i_conv_clock, 4) && !$past(i_standby_request, 3))
      else $error("word changed away from a clock fall");
   AST_STROBE_PULSE: assert property (o_word_strobe |=> !o_word_strobe)
      else $error("strobe longer than one cycle");
   AST_STROBE_AFTER_FALL: assert property (o_word_strobe |-> $past(i_conv_clock, 5)
      && !$past(i_conv_clock, 4) && !$past(i_standby_request, 4) && !$past(i_standby_request, 3))
      else $error("strobe without a converting fall");
   AST_WAKE_EARLY: assert property ($rose(o_wake_done) |-> low_cnt >= 4'h7)
      else $error("wake flag before seven cycles");
   AST_WAKE_LATE: assert property (low_cnt == 4'hE |-> o_wake_done)
      else $error("wake flag late");
endmodule

// ---- verif/pso_capture_model.sv ----
/*
 * Capture logic on the far side of the output word: resolves the tristate bus and latches words.
 * Assumes the strobe marks a settled word; undriven bits float, there is no pull resistor.
 */
module pso_capture_model
   import pso_pkg::*;
(
   input  wire logic [WORD_W-1:0] i_data,
   input  wire logic [WORD_W-1:0] i_data_oe,
   input  wire logic              i_clock,
   input  wire logic              i_word_strobe,
   input  wire logic              i_wake_done,
   output logic      [WORD_W-1:0] o_word,
   output logic                   o_got = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [WORD_W-1:0] bus;
   logic [WORD_W-1:0] last = '0;

   // ==========================================================
   // floating bits show the inverse of their last level, so a stale word never matches
   always_comb bus = (i_data & i_data_oe) | (~last & ~i_data_oe);

   always @(posedge i_clock) begin
      last <= bus;
      o_got <= 1'b0;
      if (i_word_strobe && i_wake_done && (&i_data_oe)) begin
         o_word <= bus;
         o_got <= 1'b1;
      end
   end
endmodule

// ---- verif/test_pso_sample_port.sv ----
/*
 * Self-checking bench for the sample output port with random and corner sample levels.
 * Assumes converter clock phases of six (high) and seven (low) system cycles, well above the two-cycle minimum.
 */
module test_pso_sample_port
   import pso_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              i_clock = 0, i_sys_rst = 1, i_clk_en = 1, conv = 1, stby = 1, oe_n = 0;
   logic [MV_W-1:0]   analog = '0, top = '0, bot = '0;
   logic [WORD_W-1:0] o_data, o_data_oe, o_word, held;
   logic              o_word_strobe, o_wake_done, o_got;
   logic [WORD_W-1:0] codes[$];
   int                errors = 0, cmp_count = 0, seed = 32'h95b6, got_n = 0, strobes = 0, n, s0;

   always #50 i_clock = ~i_clock;

   pso_sample_port pso_sample_port_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_conv_clock(conv), .i_standby_request(stby), .i_output_enable_n(oe_n), .i_analog_input(analog),
      .i_ref_top_sense(top), .i_ref_bottom_sense(bot), .o_data(o_data), .o_data_oe(o_data_oe),
      .o_word_strobe(o_word_strobe), .o_wake_done(o_wake_done));
   pso_capture_model pso_capture_model_i (.i_data(o_data), .i_data_oe(o_data_oe), .i_clock(i_clock),
      .i_word_strobe(o_word_strobe), .i_wake_done(o_wake_done), .o_word(o_word), .o_got(o_got));

   // ==========================================================
   // helpers
   function automatic logic [WORD_W-1:0] exp_code(logic [MV_W-1:0] v, logic [MV_W-1:0] t, logic [MV_W-1:0] b);
      int q;
      if (v < b) return CODE_ZERO;
      if (v > t || t <= b) return CODE_FULL;
      q = ((v - b) * 1024) / (t - b);
      return (q > 1023) ? CODE_FULL : WORD_W'(q);
   endfunction

   task automatic check(string what, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
      cmp_count++;
      if (exp !== got) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic tick(int k);
      repeat (k) @(posedge i_clock);
   endtask

   // one converter clock period; the level is changed at the rise of the clock so it is settled at the fall
   task automatic conv_cycle(logic [MV_W-1:0] v, logic [MV_W-1:0] t, logic [MV_W-1:0] b);
      @(posedge i_clock);
      analog <= v;
      top <= t;
      bot <= b;
      conv <= 1'b1;
      tick(6);
      conv <= 1'b0;
      if (!stby) codes.push_back(exp_code(v, t, b));
      tick(6);
   endtask

   task automatic wait_wake();
      n = 0;
      while (o_wake_done !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      if (n >= 20) begin
         errors++;
         tally_and_finish();
      end else begin
         check("wake time", 10'h001, WORD_W'(n >= 7 && n <= 14));
      end
   endtask

   task automatic random_run(int k);
      logic [MV_W-1:0] b;
      s0 = got_n;
      repeat (k) begin
         b = MV_W'(1000 + ($random(seed) & 16'h3FF));
         conv_cycle(MV_W'($random(seed) & 16'h0FFF), b + MV_W'(16'h400 + ($random(seed) & 16'h7FF)), b);
      end
      tick(12);
      check("word count", 10'h001, WORD_W'(got_n - s0 >= k - 3));
   endtask

   always @(posedge i_clock) begin
      if (o_word_strobe === 1'b1) strobes++;
      if (o_got === 1'b1 && codes.size() >= 3) begin
         got_n++;
         check("word", codes[codes.size() - 3], o_word);
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      tick(20);
      check("reset oe", 10'h000, o_data_oe);
      i_sys_rst <= 1'b0;
      tick(3);
      check("standby after reset", 10'h000, o_data_oe);
      stby <= 1'b0;
      wait_wake();
      codes.delete();
      for (int i = 0; i < 10; i++) begin
         conv_cycle((i == 9) ? 16'h05DC : MV_W'(i * 500 - ((i % 2) ? 1 : 0)), (i == 9) ? 16'h07D0 : 16'h0BB8,
                    (i == 9) ? 16'h07D0 : 16'h03E8);
      end
      random_run(30);
      $display("test corners and random done");
      oe_n <= 1'b1;
      tick(4);
      check("oe off", 10'h000, o_data_oe);
      s0 = got_n;
      repeat (3) conv_cycle(16'h0800, 16'h0BB8, 16'h03E8);
      check("no capture while off", 10'h000, WORD_W'(got_n - s0));
      oe_n <= 1'b0;
      tick(4);
      check("oe on", 10'h3FF, o_data_oe);
      $display("test output enable done");
      // a conversion clock cycle while frozen must leave no trace, then or later
      i_clk_en <= 1'b0;
      held = o_data;
      s0 = strobes;
      conv <= 1'b1;
      tick(6);
      conv <= 1'b0;
      tick(6);
      check("freeze data", held, o_data);
      check("freeze strobes", 10'h000, WORD_W'(strobes - s0));
      i_clk_en <= 1'b1;
      tick(8);
      check("no late word after freeze", 10'h000, WORD_W'(strobes - s0));
      $display("test clock enable done");
      stby <= 1'b1;
      tick(4);
      check("standby oe", 10'h000, o_data_oe);
      check("standby wake", 10'h000, WORD_W'(o_wake_done));
      s0 = strobes;
      repeat (3) conv_cycle(MV_W'($random(seed) & 16'h0FFF), 16'h0BB8, 16'h03E8);
      check("standby strobes", 10'h000, WORD_W'(strobes - s0));
      codes.delete();
      stby <= 1'b0;
      wait_wake();
      random_run(8);
      $display("test standby done");
      tally_and_finish();
   end
endmodule

bind pso_sample_port pso_sample_port_properties pso_sample_port_properties_i (.i_clock(i_clock),
   .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_conv_clock(i_conv_clock), .i_standby_request(i_standby_request),
   .i_output_enable_n(i_output_enable_n), .i_analog_input(i_analog_input), .i_ref_top_sense(i_ref_top_sense),
   .i_ref_bottom_sense(i_ref_bottom_sense), .o_data(o_data), .o_data_oe(o_data_oe),
   .o_word_strobe(o_word_strobe), .o_wake_done(o_wake_done));
